// ==== src/dmaef_top.sv ====
/*
 * dmaef_top: channel 6 and 7 event flags of a DMA controller, with a
 * flag-clear register, a read-clear interrupt status and a mask.
 * Assumes event inputs are one-cycle strobes synchronous to clock,
 * and an AXI4-Lite master on the register bus.
 */
`timescale 1ns/1ns
module dmaef_top #(
	parameter int ADDR_W = 4
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              ch6_half_evt,
	input  wire logic              ch6_err_evt,
	input  wire logic              ch7_done_evt,
	input  wire logic              ch7_half_evt,
	input  wire logic              ch7_err_evt,
	output logic                   ch6_half_xfer_flag,
	output logic                   ch6_xfer_error_flag,
	output logic                   ch7_any_event_flag,
	output logic                   ch7_xfer_done_flag,
	output logic                   ch7_half_xfer_flag,
	output logic                   irq
);
	import dmaef_pkg::*;

	logic                  wr_en;
	logic [ADDR_W-1:0]     wr_addr;
	logic [31:0]           wr_data;
	logic [3:0]            wr_strb;
	logic [31:0]           wr_lanes;
	logic                  wr_err;
	logic                  rd_en;
	logic [ADDR_W-1:0]     rd_addr;
	logic [31:0]           rd_data;
	logic                  rd_err;
	logic [FLAG_NUM-1:0]   flag_set;
	logic [FLAG_NUM-1:0]   flag_clr;
	logic [FLAG_NUM-1:0]   flags;
	logic [FLAG_NUM-1:0]   irq_clr;
	logic [FLAG_NUM-1:0]   irq_sts;
	logic [FLAG_NUM-1:0]   irq_mask_r;
	logic [FLAG_NUM-1:0]   irq_mask_nxt;
	logic                  irq_r;
	logic                  irq_nxt;
	logic                  ch7_evt;

	initial begin
		if (ADDR_W < 4 || ADDR_W > 32)
			$error("dmaef_top: ADDR_W must be 4 to 32");
	end

	// bit mask of the byte lanes enabled by a strobe
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = 32'h00000000;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				m[i*8 +: 8] = 8'hFF;
		return m;
	endfunction : lane_mask

	// word offset within the block
	function automatic logic [3:0] reg_ofs(input logic [ADDR_W-1:0] a);
		return {a[3:2], 2'h0};
	endfunction : reg_ofs

	dmaef_axil_slave #(
		.ADDR_W (ADDR_W)
	) u_bus (
		.clock   (clock),
		.rst_n   (rst_n),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	// event to flag mapping
	always_comb begin
		ch7_evt                = ch7_done_evt | ch7_half_evt | ch7_err_evt;
		flag_set               = '0;
		flag_set[IDX_CH6_HALF] = ch6_half_evt;
		flag_set[IDX_CH6_ERR]  = ch6_err_evt;
		flag_set[IDX_CH7_ANY]  = ch7_evt;
		flag_set[IDX_CH7_DONE] = ch7_done_evt;
		flag_set[IDX_CH7_HALF] = ch7_half_evt;
	end

	assign wr_lanes = lane_mask(wr_strb);

	// only ones in enabled lanes of a flag-clear write clear a flag
	always_comb begin
		flag_clr = '0;
		if (wr_en && !wr_err && reg_ofs(wr_addr) == OFS_FLAG_CLEAR)
			flag_clr = wr_data[POS_FLAG_LSB +: FLAG_NUM] & wr_lanes[POS_FLAG_LSB +: FLAG_NUM];
	end

	dmaef_flag_bit #(
		.WIDTH (FLAG_NUM)
	) u_flags (
		.clock (clock),
		.rst_n (rst_n),
		.set   (flag_set),
		.clr   (flag_clr),
		.flag  (flags)
	);

	assign ch6_half_xfer_flag  = flags[IDX_CH6_HALF];
	assign ch6_xfer_error_flag = flags[IDX_CH6_ERR];
	assign ch7_any_event_flag  = flags[IDX_CH7_ANY];
	assign ch7_xfer_done_flag  = flags[IDX_CH7_DONE];
	assign ch7_half_xfer_flag  = flags[IDX_CH7_HALF];

	// interrupt status cleared by reading it
	assign irq_clr = (rd_en && !rd_err && reg_ofs(rd_addr) == OFS_IRQ_STATUS) ? {FLAG_NUM{1'b1}} : '0;

	dmaef_flag_bit #(
		.WIDTH (FLAG_NUM)
	) u_irq_sts (
		.clock (clock),
		.rst_n (rst_n),
		.set   (flag_set),
		.clr   (irq_clr),
		.flag  (irq_sts)
	);

	always_comb begin
		irq_mask_nxt = irq_mask_r;
		if (wr_en && !wr_err && reg_ofs(wr_addr) == OFS_IRQ_MASK)
			irq_mask_nxt = (wr_data[FLAG_NUM-1:0] & wr_lanes[FLAG_NUM-1:0])
				| (irq_mask_r & ~wr_lanes[FLAG_NUM-1:0]);
		irq_nxt = |(irq_sts & irq_mask_r);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_r <= RST_IRQ_MASK;
			irq_r      <= 1'b0;
		end else begin
			irq_mask_r <= irq_mask_nxt;
			irq_r      <= irq_nxt;
		end
	end

	assign irq = irq_r;

	// read decode; status writes change nothing stored, flag-clear reads as zero
	always_comb begin
		rd_data = RST_RDATA;
		rd_err  = 1'b0;
		case (reg_ofs(rd_addr))
			OFS_STATUS:     rd_data[POS_FLAG_LSB +: FLAG_NUM] = flags;
			OFS_FLAG_CLEAR: rd_data = RST_RDATA;
			OFS_IRQ_STATUS: rd_data[FLAG_NUM-1:0] = irq_sts;
			OFS_IRQ_MASK:   rd_data[FLAG_NUM-1:0] = irq_mask_r;
			default:        rd_err = 1'b1;
		endcase
		if (rd_addr[ADDR_W-1:0] > ADDR_W'(OFS_IRQ_MASK) + ADDR_W'(3))
			rd_err = 1'b1;
		wr_err = wr_addr > ADDR_W'(OFS_IRQ_MASK) + ADDR_W'(3);
	end

	property p_ch6_err_set;
		@(posedge clock) disable iff (!rst_n)
		ch6_err_evt |=> ch6_xfer_error_flag && (rd_data[POS_CH6_ERR] == 1'b1 || reg_ofs(rd_addr) != OFS_STATUS);
	endproperty
	a_ch6_err_set: assert property (p_ch6_err_set) else $error("ch6 error flag not set");

	property p_ch7_any_hw_only;
		@(posedge clock) disable iff (!rst_n)
		$rose(ch7_any_event_flag) |-> $past(ch7_evt);
	endproperty
	a_ch7_any_hw_only: assert property (p_ch7_any_hw_only) else $error("ch7 global flag rose without event");

	property p_ch7_done_set;
		@(posedge clock) disable iff (!rst_n)
		ch7_done_evt |=> ch7_xfer_done_flag && ch7_any_event_flag;
	endproperty
	a_ch7_done_set: assert property (p_ch7_done_set) else $error("ch7 done flag not set");

	property p_ch7_half_set;
		@(posedge clock) disable iff (!rst_n)
		ch7_half_evt |=> ch7_half_xfer_flag && ch7_any_event_flag;
	endproperty
	a_ch7_half_set: assert property (p_ch7_half_set) else $error("ch7 half flag not set");

	property p_ch6_half_set;
		@(posedge clock) disable iff (!rst_n)
		ch6_half_evt |=> ch6_half_xfer_flag;
	endproperty
	a_ch6_half_set: assert property (p_ch6_half_set) else $error("ch6 half flag not set");

	property p_clear_by_one;
		@(posedge clock) disable iff (!rst_n)
		wr_en && reg_ofs(wr_addr) == OFS_FLAG_CLEAR && wr_data[POS_CH7_DONE] && wr_strb[3] && !ch7_done_evt
			|=> !ch7_xfer_done_flag;
	endproperty
	a_clear_by_one: assert property (p_clear_by_one) else $error("flag-clear write did not clear");

	property p_status_read_only;
		@(posedge clock) disable iff (!rst_n)
		wr_en && reg_ofs(wr_addr) == OFS_STATUS && ch6_half_xfer_flag |=> ch6_half_xfer_flag;
	endproperty
	a_status_read_only: assert property (p_status_read_only) else $error("status write changed a flag");

	property p_ch7_err_global;
		@(posedge clock) disable iff (!rst_n)
		ch7_err_evt && !ch7_done_evt && !ch7_half_evt |=> ch7_any_event_flag ##1 ch7_any_event_flag || $past(flag_clr[IDX_CH7_ANY]);
	endproperty
	a_ch7_err_global: assert property (p_ch7_err_global) else $error("ch7 error missing from global flag");

	property p_reset_zero;
		@(posedge clock)
		!rst_n |-> flags == RST_FLAGS;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("flags not zero in reset");

	property p_zero_keeps;
		@(posedge clock) disable iff (!rst_n)
		wr_en && reg_ofs(wr_addr) == OFS_FLAG_CLEAR && !wr_data[POS_CH7_HALF]
			&& ch7_half_xfer_flag |=> ch7_half_xfer_flag;
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("zero in flag-clear changed a flag");

	property p_write_resp;
		@(posedge clock) disable iff (!rst_n)
		awvalid && awready && wvalid && wready |-> ##2 bvalid;
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("write response late");

	property p_set_wins;
		@(posedge clock) disable iff (!rst_n)
		flag_set[IDX_CH6_ERR] && flag_clr[IDX_CH6_ERR] |=> ch6_xfer_error_flag;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle set");

	property p_bad_write_inert;
		@(posedge clock) disable iff (!rst_n)
		wr_en && wr_err && flag_set == '0 |=> flags == $past(flags) && irq_mask_r == $past(irq_mask_r);
	endproperty
	a_bad_write_inert: assert property (p_bad_write_inert) else $error("unmapped write changed state");

	property p_irq_level;
		@(posedge clock) disable iff (!rst_n)
		(irq_sts & irq_mask_r) != '0 |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("masked-in status without interrupt");

	property p_read_clears;
		@(posedge clock) disable iff (!rst_n)
		rd_en && reg_ofs(rd_addr) == OFS_IRQ_STATUS && !rd_err && flag_set == '0 |=> irq_sts == '0;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

	c_clear: cover property (@(posedge clock) disable iff (!rst_n) ch6_xfer_error_flag ##[1:20] !ch6_xfer_error_flag);
	c_irq: cover property (@(posedge clock) disable iff (!rst_n) $rose(irq));
	c_set_vs_clear: cover property (@(posedge clock) disable iff (!rst_n) (flag_set & flag_clr) != '0);
	c_read: cover property (@(posedge clock) disable iff (!rst_n) rvalid && rready && rdata != RST_RDATA);

endmodule : dmaef_top

// ==== src/dmaef_pkg.sv ====
/*
 * dmaef_pkg: register map, field positions, reset values and the write
 * state type of the channel 6/7 event flag block.
 * Assumes a 32-bit AXI4-Lite register bus and one 125 MHz clock.
 */
package dmaef_pkg;

	localparam int          DATA_W          = 32;
	localparam int          FLAG_NUM        = 5;

	// byte offsets of the registers
	localparam logic [3:0]  OFS_STATUS      = 4'h0;
	localparam logic [3:0]  OFS_FLAG_CLEAR  = 4'h4;
	localparam logic [3:0]  OFS_IRQ_STATUS  = 4'h8;
	localparam logic [3:0]  OFS_IRQ_MASK    = 4'hC;

	// flag positions in the status and flag-clear registers
	localparam int          POS_CH6_HALF    = 26;
	localparam int          POS_CH6_ERR     = 27;
	localparam int          POS_CH7_ANY     = 28;
	localparam int          POS_CH7_DONE    = 29;
	localparam int          POS_CH7_HALF    = 30;
	localparam int          POS_FLAG_LSB    = POS_CH6_HALF;

	// flag vector index, same order as the status bits
	localparam int          IDX_CH6_HALF    = 0;
	localparam int          IDX_CH6_ERR     = 1;
	localparam int          IDX_CH7_ANY     = 2;
	localparam int          IDX_CH7_DONE    = 3;
	localparam int          IDX_CH7_HALF    = 4;

	localparam logic [4:0]  RST_FLAGS       = 5'h00;
	localparam logic [4:0]  RST_IRQ_STATUS  = 5'h00;
	localparam logic [4:0]  RST_IRQ_MASK    = 5'h00;
	localparam logic [31:0] RST_RDATA       = 32'h00000000;

	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// write sequence, one bit changes per step except RESP back to IDLE
	typedef enum logic [1:0] {
		WR_IDLE = 2'h0,
		WR_EXEC = 2'h1,
		WR_RESP = 2'h3
	} dmaef_wr_state_type;

endpackage : dmaef_pkg

// ==== src/dmaef_flag_bit.sv ====
/*
 * dmaef_flag_bit: a vector of sticky flags, set by hardware, cleared by
 * a per-bit clear strobe.
 * Assumes set and clear are synchronous one-cycle strobes.
 */
`timescale 1ns/1ns
module dmaef_flag_bit #(
	parameter int WIDTH = 5
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] set,
	input  wire logic [WIDTH-1:0] clr,
	output logic      [WIDTH-1:0] flag
);
	import dmaef_pkg::*;

	logic [WIDTH-1:0] flag_r;
	logic [WIDTH-1:0] flag_nxt;

	initial begin
		if (WIDTH < 1)
			$error("dmaef_flag_bit: WIDTH must be at least 1");
	end

	// a set in the clearing cycle wins
	always_comb begin
		flag_nxt = set | (flag_r & ~clr);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			flag_r <= '0;
		else
			flag_r <= flag_nxt;
	end

	assign flag = flag_r;

endmodule : dmaef_flag_bit

// ==== src/dmaef_axil_slave.sv ====
/*
 * dmaef_axil_slave: AXI4-Lite slave front end, turning bus transfers
 * into one-cycle register write and read strobes.
 * Assumes the register file decodes rd_data/rd_err and wr_err combinationally.
 */
`timescale 1ns/1ns
module dmaef_axil_slave #(
	parameter int ADDR_W = 4
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   wr_en,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb,
	input  wire logic              wr_err,
	output logic                   rd_en,
	output logic [ADDR_W-1:0]      rd_addr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_err
);
	import dmaef_pkg::*;

	dmaef_wr_state_type wst_r, wst_nxt;
	logic              aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0]       wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0]        wstrb_r, wstrb_nxt;
	logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic              rvalid_r, rvalid_nxt;

	initial begin
		if (ADDR_W < 4)
			$error("dmaef_axil_slave: ADDR_W must be at least 4");
	end

	assign awready = (wst_r == WR_IDLE) && !aw_got_r;
	assign wready  = (wst_r == WR_IDLE) && !w_got_r;
	assign bvalid  = (wst_r == WR_RESP);
	assign bresp   = bresp_r;
	assign wr_en   = (wst_r == WR_EXEC);
	assign wr_addr = awaddr_r;
	assign wr_data = wdata_r;
	assign wr_strb = wstrb_r;
	assign arready = !rvalid_r;
	assign rd_en   = arvalid && !rvalid_r;
	assign rd_addr = araddr;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;

	// address and data taken in either order
	always_comb begin
		wst_nxt    = wst_r;
		aw_got_nxt = aw_got_r | (awvalid & awready);
		w_got_nxt  = w_got_r | (wvalid & wready);
		awaddr_nxt = (awvalid && awready) ? awaddr : awaddr_r;
		wdata_nxt  = (wvalid && wready) ? wdata : wdata_r;
		wstrb_nxt  = (wvalid && wready) ? wstrb : wstrb_r;
		bresp_nxt  = bresp_r;
		case (wst_r)
			WR_IDLE: begin
				if (aw_got_nxt && w_got_nxt)
					wst_nxt = WR_EXEC;
			end
			WR_EXEC: begin
				bresp_nxt  = wr_err ? RESP_SLVERR : RESP_OKAY;
				aw_got_nxt = 1'b0;
				w_got_nxt  = 1'b0;
				wst_nxt    = WR_RESP;
			end
			WR_RESP: begin
				if (bready)
					wst_nxt = WR_IDLE;
			end
			default: begin
				wst_nxt = WR_IDLE;
			end
		endcase
	end

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (rd_en) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rd_err ? RST_RDATA : rd_data;
			rresp_nxt  = rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid_r && rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wst_r    <= WR_IDLE;
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awaddr_r <= '0;
			wdata_r  <= RST_RDATA;
			wstrb_r  <= 4'h0;
			bresp_r  <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r  <= RST_RDATA;
			rresp_r  <= RESP_OKAY;
		end else begin
			wst_r    <= wst_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r  <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r  <= wdata_nxt;
			wstrb_r  <= wstrb_nxt;
			bresp_r  <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r  <= rdata_nxt;
			rresp_r  <= rresp_nxt;
		end
	end

endmodule : dmaef_axil_slave

// ==== tb/tb.sv ====
/*
 * tb: self-checking bench for the channel 6/7 event flag block.
 * Assumes dmaef_top with an AXI4-Lite slave, one 125 MHz clock, async low reset.
 */
`timescale 1ns/1ns
module tb;
	import dmaef_pkg::*;

	localparam int CYCLE_MAX = 5000;

	typedef struct {
		logic [4:0]  evt;
		logic [31:0] exp;
	} dmaef_row_type;

	logic        clock;
	logic        rst_n;
	logic [4:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [4:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic [4:0]  evt;
	logic [4:0]  flags;
	logic        irq;
	int          n_mismatch;
	int          compares;
	int          cycles = 0;
	logic [31:0] rd_val;
	logic [1:0]  rd_resp;
	dmaef_row_type rows [6];

	dmaef_top #(.ADDR_W(5)) u_dmaef_top (
		.clock(clock), .rst_n(rst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ch6_half_evt(evt[0]), .ch6_err_evt(evt[1]), .ch7_err_evt(evt[2]),
		.ch7_done_evt(evt[3]), .ch7_half_evt(evt[4]),
		.ch6_half_xfer_flag(flags[0]), .ch6_xfer_error_flag(flags[1]),
		.ch7_any_event_flag(flags[2]), .ch7_xfer_done_flag(flags[3]),
		.ch7_half_xfer_flag(flags[4]), .irq(irq)
	);

	always #4 clock = ~clock;

	task automatic conclude();
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == CYCLE_MAX) begin
			n_mismatch = n_mismatch + 1;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// values seen 1 ns after an edge are those sampled at the next edge
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		logic       ta;
		logic       tw;
		logic       b;
		logic [1:0] rs;
		b = 1'b0;
		rs = 2'h0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			#1;
			ta = awvalid && awready;
			tw = wvalid && wready;
			b = bvalid;
			rs = bresp;
			@(posedge clock);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk({30'h0, rs}, {30'h0, er});
	endtask : axi_wr

	task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic rv;
		rv = 1'b0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rv) begin
			#1;
			ta = arvalid && arready;
			rv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clock);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask : axi_rd

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
		axi_rd(a, rd_val, rd_resp);
		chk(rd_val, exp);
	endtask : rd_chk

	task automatic pulse(input logic [4:0] v);
		@(posedge clock);
		evt <= v;
		@(posedge clock);
		evt <= 5'h00;
	endtask : pulse

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, evt, n_mismatch, compares} = '0;
		rows = '{'{5'h01, 32'h04000000}, '{5'h02, 32'h08000000}, '{5'h04, 32'h10000000},
			'{5'h08, 32'h30000000}, '{5'h10, 32'h50000000}, '{5'h1F, 32'h7C000000}};
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		// reset values
		rd_chk(5'h00, 32'h00000000);
		rd_chk(5'h0C, 32'h00000000);
		rd_chk(5'h08, 32'h00000000);
		$display("test reset done");
		// each event kind sets its own flags, then a full clear
		foreach (rows[i]) begin
			pulse(rows[i].evt);
			rd_chk(5'h00, rows[i].exp);
			chk({27'h0, flags}, {27'h0, rows[i].exp[30:26]});
			axi_wr(5'h04, 32'h7C000000, 4'hF, RESP_OKAY);
			rd_chk(5'h00, 32'h00000000);
		end
		$display("test table done");
		// read-only status, lane strobes, single-bit and zero clears
		pulse(5'h1F);
		axi_wr(5'h00, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
		rd_chk(5'h00, 32'h7C000000);
		axi_wr(5'h04, 32'hFFFFFFFF, 4'h7, RESP_OKAY);
		rd_chk(5'h00, 32'h7C000000);
		axi_wr(5'h04, 32'h08000000, 4'hF, RESP_OKAY);
		rd_chk(5'h00, 32'h74000000);
		axi_wr(5'h04, 32'h00000000, 4'hF, RESP_OKAY);
		rd_chk(5'h00, 32'h74000000);
		axi_wr(5'h04, 32'h10000000, 4'hF, RESP_OKAY);
		rd_chk(5'h00, 32'h64000000);
		chk({27'h0, flags}, 32'h00000019);
		axi_wr(5'h04, 32'h64000000, 4'hF, RESP_OKAY);
		rd_chk(5'h00, 32'h00000000);
		rd_chk(5'h04, 32'h00000000);
		$display("test clear done");
		// interrupt status, mask and level output
		axi_rd(5'h08, rd_val, rd_resp);
		rd_chk(5'h08, 32'h00000000);
		pulse(5'h02);
		repeat (2) @(posedge clock);
		#1 chk({31'h0, irq}, 32'h0);
		rd_chk(5'h08, 32'h00000002);
		rd_chk(5'h08, 32'h00000000);
		axi_wr(5'h0C, 32'h0000001F, 4'hF, RESP_OKAY);
		rd_chk(5'h0C, 32'h0000001F);
		pulse(5'h10);
		@(posedge clock);
		#1 chk({31'h0, irq}, 32'h1);
		rd_chk(5'h08, 32'h00000014);
		repeat (3) @(posedge clock);
		#1 chk({31'h0, irq}, 32'h0);
		axi_wr(5'h0C, 32'h00000001, 4'hF, RESP_OKAY);
		pulse(5'h02);
		repeat (2) @(posedge clock);
		#1 chk({31'h0, irq}, 32'h0);
		pulse(5'h01);
		repeat (2) @(posedge clock);
		#1 chk({31'h0, irq}, 32'h1);
		$display("test irq done");
		// unmapped offset
		axi_wr(5'h10, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
		axi_wr(5'h14, 32'h7C000000, 4'hF, RESP_SLVERR);
		axi_rd(5'h10, rd_val, rd_resp);
		chk(rd_val, 32'h00000000);
		chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
		axi_rd(5'h18, rd_val, rd_resp);
		chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
		rd_chk(5'h08, 32'h00000003);
		rd_chk(5'h00, 32'h5C000000);
		$display("test unmapped done");
		// set and clear of one flag land in the same cycle
		fork
			axi_wr(5'h04, 32'h08000000, 4'hF, RESP_OKAY);
			begin
				repeat (2) @(posedge clock);
				evt <= 5'h02;
				@(posedge clock);
				evt <= 5'h00;
			end
		join
		rd_chk(5'h00, 32'h5C000000);
		$display("test set-clear done");
		// second reset in mid-run
		@(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock);
		#1 chk({26'h0, flags, irq}, 32'h0);
		@(posedge clock);
		rst_n <= 1'b1;
		rd_chk(5'h00, 32'h00000000);
		rd_chk(5'h0C, 32'h00000000);
		$display("test rereset done");
		conclude();
	end
endmodule : tb
